// >>> design/lbp_pkg.sv
`default_nettype none
package lbp_pkg;

	// ------------------------------
	// clocking and timebases
	// ------------------------------
	localparam int CLK_HZ       = 100_000_000;
	localparam int FAST_HZ      = 48_000_000;
	localparam int SLOW_HZ      = 32_768;
	localparam int CLK_MHZ      = CLK_HZ / 1_000_000;
	localparam int FAST_MHZ     = FAST_HZ / 1_000_000;
	localparam int WDT_TICK_MS  = 200;
	// slow ticks per watchdog tick, rounded down
	localparam int WDT_DIV_DEF  = SLOW_HZ * WDT_TICK_MS / 1000;

	// ------------------------------
	// register map
	// ------------------------------
	localparam logic [7:0] OFF_CFG  = 8'h00;
	localparam logic [7:0] OFF_LIM  = 8'h04;
	localparam logic [7:0] OFF_DLY  = 8'h08;
	localparam logic [7:0] OFF_STEP = 8'h0c;
	localparam logic [7:0] OFF_INT  = 8'h10;
	localparam logic [7:0] OFF_STAT = 8'h14;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// ------------------------------
	// fields and reset values
	// ------------------------------
	typedef enum logic [1:0] {
		CTL_OFF     = 2'h0,
		CTL_BREATHE = 2'h1,
		CTL_BLINK   = 2'h2,
		CTL_ON      = 2'h3
	} lbp_ctl_type;

	typedef struct packed {
		logic [7:0]  wdt_reload;
		logic        soft_reset;
		logic        enable_update;
		logic [1:0]  width_sel;
		logic        mirrored;
		logic        clk_fast;
		lbp_ctl_type control;
	} lbp_cfg_type;

	typedef struct packed {
		logic [7:0] high_limit;
		logic [7:0] low_limit;
	} lbp_lim_type;

	typedef struct packed {
		logic [11:0] high_hold;
		logic [11:0] low_reload;
	} lbp_dly_type;

	localparam logic [7:0]  WDT_RST = 8'h14;
	localparam lbp_cfg_type CFG_RST = '{WDT_RST, 1'b0, 1'b0, 2'h0,
		1'b0, 1'b0, CTL_OFF};
	localparam logic [1:0]  WID_7   = 2'h1;
	localparam logic [7:0]  MAX_8   = 8'hff;
	localparam logic [7:0]  MAX_7   = 8'h7f;
	localparam logic [7:0]  MAX_6   = 8'h3f;

	// ramp states, gray order along the cycle
	typedef enum logic [1:0] {
		ST_RISE = 2'b00,
		ST_HIGH = 2'b01,
		ST_FALL = 2'b11,
		ST_LOW  = 2'b10
	} lbp_state_type;

endpackage
`default_nettype wire

// >>> design/lbp_core.sv
// How it works
// - blink mode on fast clock acts as general PWM, 8-bit width.
// - blink period is source clock over 256 times reload plus one.
// - watchdog has 8-bit down counter and 8-bit reload field.
// - reset loads watchdog counter with default 14h, four seconds.
// - config write or low-limit byte write reloads watchdog counter.
// - in general PWM mode, nonzero watchdog counter decrements once per 5 Hz tick.
// - step from one to zero pulses interrupt, forces control to on.
// - watchdog holds its count while the 5 Hz tick is absent.
// - reload zero disables watchdog; each count is 200 ms.
// - breathing phase counter wraps at 255, 127 or 63 by width.
// - control off clears counters and working registers.
// - rising ramp adds segment step on each delay update.
// - at high limit hold for hold time, then ramp down.
// - at or below low limit hold, then ramp up again.
// - symmetric mode picks segment from duty bits 7:5.
// - asymmetric mode picks segment from falling flag and duty 7:6.
// - blink delay counter runs on chosen clock, prescales PWM counter.
// - delay reload zero passes source clock straight to PWM counter.
// - blink mode PWM counter is always 8-bit.
// - blink duty zero is off; control 3 forces fully on.
// - step, interval and hold ignored in blink mode.
// - watchdog interrupt lasts exactly one clock cycle.
// - limit writes staged, applied when PWM period ends.
// - other staged values copied at period end only if update enabled.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lbp_core
	import lbp_pkg::*;
#(
	parameter int WDT_DIV = WDT_DIV_DEF
) (
	input  wire logic        MCLK_I,
	input  wire logic        RESET_I,
	input  wire logic [7:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [7:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	output logic             LED_O,
	output logic             WDT_IRQ_O
);

	// ------------------------------
	// declarations
	// ------------------------------
	logic [7:0]    aw_addr_q;
	logic          aw_have_q;
	logic [31:0]   w_data_q;
	logic [3:0]    w_strb_q;
	logic          w_have_q;
	logic          bvalid_q;
	logic [1:0]    bresp_q;
	logic          rvalid_q;
	logic [1:0]    rresp_q;
	logic [31:0]   rdata_q;
	logic [31:0]   rd_data;
	logic          rd_ok;
	logic          wr_go;
	logic          wr_cfg;
	logic          wr_lim;
	logic [31:0]   wr_cfg_word;
	lbp_cfg_type   cfg_q;
	lbp_cfg_type   cfg_w;
	lbp_lim_type   lim_h_q;
	lbp_lim_type   lim_w_q;
	lbp_dly_type   dly_h_q;
	lbp_dly_type   dly_w_q;
	logic [31:0]   step_h_q;
	logic [31:0]   step_w_q;
	logic [31:0]   int_h_q;
	logic [31:0]   int_w_q;
	logic [6:0]    acc_fast_q;
	logic [26:0]   acc_slow_q;
	logic          t_fast_q;
	logic          t_slow_q;
	logic [12:0]   div5_q;
	logic          t5_q;
	logic [7:0]    wdt_q;
	logic          wdt_load;
	logic          wdt_fire;
	logic          irq_q;
	lbp_state_type state_q;
	logic [7:0]    duty_q;
	logic [11:0]   dly_q;
	logic [7:0]    pwm_q;
	logic          led_q;
	logic          blink;
	logic          breathe;
	logic          gp_mode;
	logic          src_tick;
	logic          pwm_adv;
	logic          per_end;
	logic [7:0]    pwm_max;
	logic [7:0]    duty_eff;
	logic [2:0]    seg;
	logic [3:0]    step_n;
	logic [3:0]    int_n;

	// byte-lane merge of a write into a register word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------
	// bus slave
	// ------------------------------
	// address and data may come in either order; held until both seen
	assign S_AXI_AWREADY_O = !aw_have_q && !bvalid_q;
	assign S_AXI_WREADY_O  = !w_have_q && !bvalid_q;
	assign S_AXI_BVALID_O  = bvalid_q;
	assign S_AXI_BRESP_O   = bresp_q;
	assign S_AXI_ARREADY_O = !rvalid_q;
	assign S_AXI_RVALID_O  = rvalid_q;
	assign S_AXI_RRESP_O   = rresp_q;
	assign S_AXI_RDATA_O   = rdata_q;
	assign wr_go  = aw_have_q && w_have_q;
	assign wr_cfg = wr_go && aw_addr_q == OFF_CFG;
	assign wr_lim = wr_go && aw_addr_q == OFF_LIM;

	// write channel capture and response
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OK;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_have_q <= 1'b1;
				w_data_q <= S_AXI_WDATA_I;
				w_strb_q <= S_AXI_WSTRB_I;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (aw_addr_q <= OFF_INT && aw_addr_q[1:0] == 2'h0)
					? RESP_OK : RESP_ERR;
			end else if (S_AXI_BREADY_I) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read decode; status word shows live engine state
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0;
		case (S_AXI_ARADDR_I)
			OFF_CFG:  rd_data = {16'h0, cfg_q};
			OFF_LIM:  rd_data = {16'h0, lim_h_q};
			OFF_DLY:  rd_data = {8'h0, dly_h_q};
			OFF_STEP: rd_data = step_h_q;
			OFF_INT:  rd_data = int_h_q;
			OFF_STAT: rd_data = {6'h0, state_q, wdt_q, duty_q, pwm_q};
			default:  rd_ok = 1'b0;
		endcase
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= RESP_OK;
		end else if (S_AXI_ARVALID_I && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_data;
			rresp_q  <= rd_ok ? RESP_OK : RESP_ERR;
		end else if (S_AXI_RREADY_I) begin
			rvalid_q <= 1'b0;
		end
	end

	// ------------------------------
	// configuration and staging
	// ------------------------------
	assign wr_cfg_word = merge({16'h0, cfg_q}, w_data_q, w_strb_q);
	assign cfg_w = wr_cfg_word[15:0];

	// config writes act at once; soft reset restores defaults
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			cfg_q <= CFG_RST;
		end else begin
			if (wr_cfg) begin
				cfg_q <= cfg_w.soft_reset ? CFG_RST : cfg_w;
			end
			if (wdt_fire) begin
				cfg_q.control <= CTL_ON;
			end
		end
	end

	// holding copies, written by software at any time
	always_ff @(posedge MCLK_I) begin
		if (RESET_I || (wr_cfg && cfg_w.soft_reset)) begin
			lim_h_q  <= '0;
			dly_h_q  <= '0;
			step_h_q <= 32'h0;
			int_h_q  <= 32'h0;
		end else if (wr_go) begin
			case (aw_addr_q)
				OFF_LIM:  lim_h_q  <= 16'(merge({16'h0, lim_h_q}, w_data_q, w_strb_q));
				OFF_DLY:  dly_h_q  <= 24'(merge({8'h0, dly_h_q}, w_data_q, w_strb_q));
				OFF_STEP: step_h_q <= merge(step_h_q, w_data_q, w_strb_q);
				OFF_INT:  int_h_q  <= merge(int_h_q, w_data_q, w_strb_q);
				default:  ;
			endcase
		end
	end

	// working copies move only at a period boundary
	always_ff @(posedge MCLK_I) begin
		if (RESET_I || cfg_q.control == CTL_OFF) begin
			lim_w_q  <= '0;
			dly_w_q  <= '0;
			step_w_q <= 32'h0;
			int_w_q  <= 32'h0;
		end else if (per_end) begin
			lim_w_q <= lim_h_q;
			if (cfg_q.enable_update) begin
				dly_w_q  <= dly_h_q;
				step_w_q <= step_h_q;
				int_w_q  <= int_h_q;
			end
		end
	end

	// ------------------------------
	// timebases
	// ------------------------------
	// fractional dividers: average rate exact, single ticks jitter
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			acc_fast_q <= 7'h00;
			t_fast_q   <= 1'b0;
		end else if (acc_fast_q >= 7'(CLK_MHZ - FAST_MHZ)) begin
			acc_fast_q <= acc_fast_q - 7'(CLK_MHZ - FAST_MHZ);
			t_fast_q   <= 1'b1;
		end else begin
			acc_fast_q <= acc_fast_q + 7'(FAST_MHZ);
			t_fast_q   <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			acc_slow_q <= 27'h0;
			t_slow_q   <= 1'b0;
		end else if (acc_slow_q >= 27'(CLK_HZ - SLOW_HZ)) begin
			acc_slow_q <= acc_slow_q - 27'(CLK_HZ - SLOW_HZ);
			t_slow_q   <= 1'b1;
		end else begin
			acc_slow_q <= acc_slow_q + 27'(SLOW_HZ);
			t_slow_q   <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			div5_q <= 13'h0;
			t5_q   <= 1'b0;
		end else begin
			t5_q <= 1'b0;
			if (t_slow_q) begin
				if (div5_q == 13'(WDT_DIV - 1)) begin
					div5_q <= 13'h0;
					t5_q   <= 1'b1;
				end else begin
					div5_q <= div5_q + 13'h1;
				end
			end
		end
	end

	// ------------------------------
	// watchdog
	// ------------------------------
	// fast-clock blink is general PWM
	assign gp_mode  = blink && cfg_q.clk_fast;
	assign wdt_load = wr_cfg || (wr_lim && w_strb_q[0]);
	// a refresh in the same cycle beats the timeout
	assign wdt_fire = gp_mode && t5_q && wdt_q == 8'h01 && !wdt_load;
	assign WDT_IRQ_O = irq_q;

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			wdt_q <= WDT_RST;
		end else if (wdt_load) begin
			// soft reset reloads the default, matching the config it leaves behind
			if (wr_cfg && cfg_w.soft_reset) begin
				wdt_q <= WDT_RST;
			end else begin
				wdt_q <= wr_cfg ? cfg_w.wdt_reload : cfg_q.wdt_reload;
			end
		end else if (gp_mode && t5_q && wdt_q != 8'h00) begin
			wdt_q <= wdt_q - 8'h01;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= wdt_fire;
		end
	end

	// ------------------------------
	// counters and ramp engine
	// ------------------------------
	assign blink    = cfg_q.control == CTL_BLINK;
	assign breathe  = cfg_q.control == CTL_BREATHE;
	assign src_tick = cfg_q.clk_fast ? t_fast_q : t_slow_q;
	assign pwm_adv  = blink ? (src_tick && dly_q == 12'h0) : (breathe && t_slow_q);

	always_comb begin
		if (blink || cfg_q.width_sel == 2'h0) begin
			pwm_max = MAX_8;
		end else if (cfg_q.width_sel == WID_7) begin
			pwm_max = MAX_7;
		end else begin
			pwm_max = MAX_6;
		end
	end
	// >= also ends a lap begun before a narrower width was chosen
	assign per_end = pwm_adv && pwm_q >= pwm_max;

	assign seg    = cfg_q.mirrored ? duty_q[7:5] : {state_q == ST_FALL, duty_q[7:6]};
	assign step_n = step_w_q[4*seg +: 4];
	assign int_n  = int_w_q[4*seg +: 4];

	// phase counter wraps at width limit
	always_ff @(posedge MCLK_I) begin
		if (RESET_I || cfg_q.control == CTL_OFF) begin
			pwm_q <= 8'h00;
		end else if (pwm_adv) begin
			pwm_q <= per_end ? 8'h00 : pwm_q + 8'h01;
		end
	end

	// delay counter: prescaler in blink, update timer in breathing
	always_ff @(posedge MCLK_I) begin
		if (RESET_I || cfg_q.control == CTL_OFF) begin
			state_q <= ST_RISE;
			duty_q  <= 8'h00;
			dly_q   <= 12'h0;
		end else if (blink) begin
			if (src_tick) begin
				dly_q <= dly_q == 12'h0 ? dly_w_q.low_reload : dly_q - 12'h1;
			end
		end else if (breathe && per_end) begin
			if (dly_q != 12'h0) begin
				dly_q <= dly_q - 12'h1;
			end else begin
				case (state_q)
					ST_RISE: begin
						if ({1'b0, duty_q} + {5'h0, step_n} >= {1'b0, lim_w_q.high_limit}) begin
							duty_q  <= lim_w_q.high_limit;
							state_q <= ST_HIGH;
							dly_q   <= dly_w_q.high_hold;
						end else begin
							duty_q <= duty_q + {4'h0, step_n};
							dly_q  <= {8'h0, int_n};
						end
					end
					ST_HIGH: begin
						state_q <= ST_FALL;
						dly_q   <= {8'h0, int_n};
					end
					ST_FALL: begin
						if ({1'b0, duty_q} <= {1'b0, lim_w_q.low_limit} + {5'h0, step_n}) begin
							duty_q  <= lim_w_q.low_limit;
							state_q <= ST_LOW;
							dly_q   <= dly_w_q.low_reload;
						end else begin
							duty_q <= duty_q - {4'h0, step_n};
							dly_q  <= {8'h0, int_n};
						end
					end
					ST_LOW: begin
						state_q <= ST_RISE;
						dly_q   <= {8'h0, int_n};
					end
					default: state_q <= ST_RISE;
				endcase
			end
		end
	end

	// ------------------------------
	// output
	// ------------------------------
	// blink duty is the low limit only
	assign duty_eff = blink ? lim_w_q.low_limit : duty_q;
	assign LED_O    = led_q;

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			led_q <= 1'b0;
		end else if (cfg_q.control == CTL_ON) begin
			led_q <= 1'b1;
		end else if (blink || breathe) begin
			led_q <= pwm_q < duty_eff;
		end else begin
			led_q <= 1'b0;
		end
	end

	// ------------------------------
	// checks
	// ------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);

	a_wdt_expire_force: assert property (
		gp_mode && t5_q && wdt_q == 8'h01 && !wdt_load
		|=> cfg_q.control == CTL_ON && WDT_IRQ_O && wdt_q == 8'h00)
		else $error("watchdog expiry did not force on");
	a_irq_one_cycle: assert property (
		WDT_IRQ_O |=> !WDT_IRQ_O)
		else $error("interrupt longer than one cycle");
	a_wdt_hold_value: assert property (
		!t5_q && !wdt_load |=> wdt_q == $past(wdt_q))
		else $error("watchdog moved without tick");
	a_wdt_reload_val: assert property (
		wdt_load |=> wdt_q == cfg_q.wdt_reload)
		else $error("watchdog not reloaded");
	a_wdt_zero_off: assert property (
		wdt_q == 8'h00 && !wdt_load |=> wdt_q == 8'h00 && !WDT_IRQ_O)
		else $error("disabled watchdog counted");
	a_off_clears: assert property (
		cfg_q.control == CTL_OFF |=> pwm_q == 8'h00 && duty_q == 8'h00 && !LED_O)
		else $error("off did not clear");
	a_phase_wrap: assert property (
		pwm_adv && pwm_q == pwm_max |=> pwm_q == 8'h00)
		else $error("phase counter wrap wrong");
	a_blink_width: assert property (
		blink && pwm_adv && pwm_q == 8'h7f |=> pwm_q == 8'h80)
		else $error("blink counter not 8-bit");
	a_force_on: assert property (
		cfg_q.control == CTL_ON |=> LED_O)
		else $error("forced on not on");
	a_limit_staged: assert property (
		!per_end && cfg_q.control != CTL_OFF |=> $stable(lim_w_q))
		else $error("limits changed mid period");

endmodule
`default_nettype wire

// >>> dv/lbp_axi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// register bus host model
// ------------------------------
module lbp_axi_host (
	input  wire logic        clk_i,
	output logic [7:0]       awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	output logic [7:0]       araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	// answers always accepted, so no ready toggling between transfers
	assign bready_o = 1'b1;
	assign rready_o = 1'b1;

	// idle channels at time zero
	initial begin
		awaddr_o = 8'h00;
		awvalid_o = 1'b0;
		wdata_o = 32'h0;
		wstrb_o = 4'h0;
		wvalid_o = 1'b0;
		araddr_o = 8'h00;
		arvalid_o = 1'b0;
	end

	// write: both channels offered, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		r = 2'bxx;
		awaddr_o <= a;
		awvalid_o <= 1'b1;
		wdata_o <= d;
		wstrb_o <= s;
		wvalid_o <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(posedge clk_i);
			if (awvalid_o && awready_i)
				awvalid_o <= 1'b0;
			if (wvalid_o && wready_i)
				wvalid_o <= 1'b0;
			if (bvalid_i === 1'b1) begin
				r = bresp_i;
				break;
			end
		end
	endtask

	// read: address held until taken, data taken with rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		r = 2'bxx;
		d = 32'h0;
		araddr_o <= a;
		arvalid_o <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(posedge clk_i);
			if (arvalid_o && arready_i)
				arvalid_o <= 1'b0;
			if (rvalid_i === 1'b1) begin
				d = rdata_i;
				r = rresp_i;
				break;
			end
		end
	endtask
endmodule
`default_nettype wire

// >>> dv/lbp_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
	$display("unexpected %s expected %h seen %h", nm, exp, got); end end
module lbp_core_bench
	import lbp_pkg::*;
;
	// short watchdog tick keeps the run small
	localparam int DIV = 4;
	logic        MCLK_I = 1'b0;
	logic        RESET_I;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, led, irq, irq_q;
	int          failures, checks, irq_cnt = 0, irq_long = 0;

	lbp_core #(.WDT_DIV(DIV)) dut (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_r),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(w_v),
		.S_AXI_WREADY_O(w_r), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(b_v),
		.S_AXI_BREADY_I(b_r), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(ar_v),
		.S_AXI_ARREADY_O(ar_r), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(r_v), .S_AXI_RREADY_I(r_r), .LED_O(led), .WDT_IRQ_O(irq));

	lbp_axi_host host (.clk_i(MCLK_I), .awaddr_o(awaddr), .awvalid_o(aw_v),
		.awready_i(aw_r), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(w_v),
		.wready_i(w_r), .bresp_i(bresp), .bvalid_i(b_v), .bready_o(b_r),
		.araddr_o(araddr), .arvalid_o(ar_v), .arready_i(ar_r), .rdata_i(rdata),
		.rresp_i(rresp), .rvalid_i(r_v), .rready_o(r_r));

	// ------------------------------
	// clock and interrupt monitor
	// ------------------------------
	always #5 MCLK_I = ~MCLK_I;

	// pulses counted, and any pulse longer than one cycle
	always @(posedge MCLK_I) begin
		if (irq === 1'b1)
			irq_cnt++;
		if (irq === 1'b1 && irq_q === 1'b1)
			irq_long++;
		irq_q = irq;
	end

	// ------------------------------
	// access and measuring tasks
	// ------------------------------
	task automatic results;
		$display("failures %0d checks %0d", failures, checks);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
		input logic [1:0] e = RESP_OK);
		logic [1:0] r;
		host.wr(a, d, s, r);
		`CHK("write response", e, r)
		if (r === 2'bxx)
			results();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e = RESP_OK);
		logic [1:0] r;
		host.rd(a, d, r);
		`CHK("read response", e, r)
		if (r === 2'bxx)
			results();
	endtask

	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er = RESP_OK);
		logic [31:0] d;
		rd(a, d, er);
		`CHK(nm, e, d & m)
	endtask

	// tolerance needed: source ticks come from a jittered accumulator
	task automatic near(input string nm, input int e, input int g, input int t);
		`CHK(nm, e, (g >= e - t && g <= e + t) ? e : g)
	endtask

	// settle past period ends so staged values land, then count
	task automatic measure(output int hi, output int rs);
		logic p;
		hi = 0;
		rs = 0;
		repeat (2400) @(posedge MCLK_I);
		p = led;
		repeat (5333) begin
			@(posedge MCLK_I);
			if (led === 1'b1)
				hi++;
			if (led === 1'b1 && p !== 1'b1)
				rs++;
			p = led;
		end
	endtask

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		logic [31:0] d;
		int hi, rs, n;
		failures = 0;
		checks = 0;
		RESET_I = 1'b1;
		repeat (8) @(posedge MCLK_I);
		RESET_I <= 1'b0;
		@(posedge MCLK_I);
		chk_rd("config at reset", OFF_CFG, 32'hffff, 32'h1400);
		chk_rd("watchdog at reset", OFF_STAT, 32'hff0000, 32'h140000);
		chk_rd("unmapped read", 8'h18, 32'hffffffff, 32'h0, RESP_ERR);
		chk_rd("unaligned read", 8'h02, 32'hffffffff, 32'h0, RESP_ERR);
		w(OFF_STAT, 32'h0, 4'hf, RESP_ERR);
		// ramp settings loaded but must not matter in blink
		w(OFF_STEP, 32'hffffffff);
		w(OFF_INT, 32'hffffffff);
		w(OFF_DLY, 32'hfff000);
		// blink on fast ticks, 6-bit width asked, update on, watchdog off
		w(OFF_CFG, 32'h0066);
		w(OFF_LIM, 32'h0040);
		measure(hi, rs);
		near("high cycles", 1333, hi, 8);
		near("periods prescale 0", 10, rs, 1);
		near("periods at 8 bits", 10, rs, 1);
		w(OFF_DLY, 32'h1);
		measure(hi, rs);
		near("periods prescale 1", 5, rs, 1);
		near("high cycles", 1333, hi, 8);
		w(OFF_CFG, 32'h0006);
		w(OFF_DLY, 32'h0);
		measure(hi, rs);
		near("periods kept", 5, rs, 1);
		w(OFF_LIM, 32'h0000);
		measure(hi, rs);
		`CHK("zero duty high", 0, hi)
		chk_rd("watchdog disabled", OFF_STAT, 32'hff0000, 32'h0);
		`CHK("irq while disabled", 0, irq_cnt)
		// control off clears counters and duty
		w(OFF_CFG, 32'h0000);
		chk_rd("cleared state", OFF_STAT, 32'hffff, 32'h0);
		`CHK("led when off", 1'b0, led)
		// breathing from the cleared state: phase steps on slow ticks, duty stays zero
		w(OFF_CFG, 32'h0001);
		repeat (2 * CLK_HZ / SLOW_HZ) @(posedge MCLK_I);
		chk_rd("breathing duty and state", OFF_STAT, 32'h0300ff00, 32'h0);
		rd(OFF_STAT, d);
		near("breathing phase steps", 2, d[7:0], 1);
		`CHK("led at zero duty", 1'b0, led)
		w(OFF_CFG, 32'h0306);
		chk_rd("watchdog load", OFF_STAT, 32'hff0000, 32'h030000);
		n = 0;
		do begin
			rd(OFF_STAT, d);
			n++;
		end while (d[23:16] === 8'h03 && n < 8000);
		if (n == 8000) begin
			failures++;
			results();
		end
		`CHK("watchdog step", 8'h02, d[23:16])
		w(OFF_LIM, 32'h10, 4'h1);
		chk_rd("watchdog refresh", OFF_STAT, 32'hff0000, 32'h030000);
		// timeout after three watchdog ticks of DIV slow ticks each
		n = 0;
		while (irq !== 1'b1 && n < 45000) begin
			@(posedge MCLK_I);
			n++;
		end
		if (n == 45000) begin
			failures++;
			results();
		end
		// refresh lands just after a tick, so three full ticks less a few cycles
		near("timeout cycles", 3 * DIV * CLK_HZ / SLOW_HZ, n, 32);
		repeat (2) @(posedge MCLK_I);
		chk_rd("forced on", OFF_CFG, 32'hffff, 32'h0307);
		measure(hi, rs);
		`CHK("full on", 5333, hi)
		`CHK("irq count", 1, irq_cnt)
		`CHK("irq longer than one cycle", 0, irq_long)
		results();
	end
endmodule
`default_nettype wire
